// file: bench/beat_sink.sv
// downstream stand-in for the sequencer: accepts beats, stalls on demand
// assumes the sequencer's mclk and rst_n; ready moves on the falling edge
`timescale 1ns/1ps
`default_nettype none
module beat_sink (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic stall_en,
  output var  logic beat_ready
);
  logic [1:0] phase_reg;

  // one stalled cycle in three, so held beats get exercised
  always_ff @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg  <= 2'h0;
      beat_ready <= 1'b0;
    end else begin
      phase_reg  <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      beat_ready <= !(stall_en && (phase_reg == 2'h2));
    end
  end
endmodule
`default_nettype wire

// file: bench/fic_uep_puncture_sequencer_tb.sv
// self-checking bench for the puncturing sequencer
// assumes the package and params header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "puncture_params.svh"
module fic_uep_puncture_sequencer_tb;
  import puncture_pkg::*;
  logic        mclk, rst_n, start_frame, stall_en;
  logic        busy, cfg_error, beat_valid, beat_ready;
  frame_cfg_t  cfg;
  logic [13:0] frame_bits;
  beat_t       beat;
  int          n_errors, tests_run, cycles;

  puncture_sequencer u_puncture_sequencer (
    .mclk(mclk), .rst_n(rst_n), .start_frame(start_frame), .cfg(cfg),
    .busy(busy), .cfg_error(cfg_error), .frame_bits(frame_bits),
    .beat(beat), .beat_valid(beat_valid), .beat_ready(beat_ready));
  beat_sink u_beat_sink (
    .mclk(mclk), .rst_n(rst_n), .stall_en(stall_en),
    .beat_ready(beat_ready));

  // free-running clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard, well above the longest frame sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_beat(input beat_t got, input beat_t exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t beat got %h exp %h", $time, got, exp);
    end
  endtask

  // bounded wait until no frame runs and the last beat has gone
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while ((busy !== 1'b0 || beat_valid !== 1'b0) && k < 400);
  endtask

  // looks in the low phase, where valid, ready and beat have settled,
  // then crosses the rising edge that takes the beat
  task automatic take_beat(output beat_t b);
    int   k;
    logic hit;
    k = 0;
    do begin
      @(negedge mclk);
      #1;
      hit = beat_valid === 1'b1 && beat_ready === 1'b1;
      k++;
    end while (!hit && k < 50);
    b = beat;
    @(posedge mclk);
  endtask

  // segments listed with the first one in element 0
  task automatic run_frame(input frame_cfg_t c, input logic [13:0] fbits,
                           input logic [3:0][8:0] segs,
                           input logic [3:0][4:0] idx,
                           input logic [3:0] pad);
    beat_t      got;
    beat_t      exp;
    logic [8:0] blk;
    wait_idle();
    cfg         = c;
    start_frame = 1'b1;
    @(negedge mclk);
    start_frame = 1'b0;
    cfg         = frame_cfg_t'(~c); // must not reach the running frame
    chk_val(busy, 32'h1, "busy after start");
    chk_val(frame_bits, fbits, "frame length");
    blk = 9'h0;
    for (int s = 0; s < 4; s++) begin
      for (int n = 0; n < segs[s]; n++) begin
        for (int q = 0; q < 4; q++) begin
          exp                = '0;
          exp.kind           = BEAT_BLOCK;
          exp.block_num      = blk;
          exp.sub_block      = q[1:0];
          exp.puncture_index = idx[s];
          take_beat(got);
          chk_beat(got, exp);
        end
        blk++;
      end
    end
    exp             = '0;
    exp.kind        = BEAT_TAIL;
    exp.tail_vector = `PS_TAIL_VECTOR;
    exp.last        = (pad == 4'h0);
    take_beat(got);
    chk_beat(got, exp);
    if (pad != 4'h0) begin
      exp          = '0;
      exp.kind     = BEAT_PAD;
      exp.pad_bits = pad;
      exp.last     = 1'b1;
      take_beat(got);
      chk_beat(got, exp);
    end
  endtask

  task automatic bad_cfg(input frame_cfg_t c);
    wait_idle();
    cfg         = c;
    start_frame = 1'b1;
    @(negedge mclk);
    start_frame = 1'b0;
    chk_val(cfg_error, 32'h1, "error pulse");
    chk_val(busy, 32'h0, "no frame on error");
    @(negedge mclk);
    chk_val(cfg_error, 32'h0, "error pulse width");
    chk_val(beat_valid, 32'h0, "no beat on error");
  endtask

  // main sequence: reset, frames of each kind, then refused settings
  initial begin
    rst_n       = 1'b0;
    start_frame = 1'b0;
    stall_en    = 1'b1;
    cfg         = '0;
    n_errors    = 0;
    tests_run   = 0;
    cycles      = 0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    // fast info: rate and level are ignored, so odd values go in
    run_frame(frame_cfg_t'{1'b1, `PS_RATE_384, 3'h0}, 14'd768,
              {9'd0, 9'd0, 9'd3, 9'd21}, {5'd0, 5'd0, 5'd15, 5'd16},
              4'h0);
    stall_en = 1'b0;
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_48, 3'h3}, 14'h0480,
              {9'h003, 9'h01a, 9'h004, 9'h003},
              {5'h09, 5'h06, 5'h0a, 5'h0f},
              4'h4);
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_32, 3'h1}, 14'd768,
              {9'd3, 9'd13, 9'd5, 9'd3}, {5'd17, 5'd12, 5'd17, 5'd24},
              4'h4);
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_32, 3'h5}, 14'd768,
              {9'd0, 9'd17, 9'd4, 9'd3}, {5'd0, 5'd2, 5'd3, 5'd5},
              4'h0);
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_64, 3'h4}, 14'd1536,
              {9'd0, 9'd33, 9'd9, 9'd6}, {5'd0, 5'd5, 5'd6, 5'd11},
              4'h0);
    stall_en = 1'b1;
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_64, 3'h2}, 14'd1536,
              {9'd3, 9'd29, 9'd10, 9'd6}, {5'd13, 5'd8, 5'd13, 5'd23},
              4'h8);
    run_frame(frame_cfg_t'{1'b0, `PS_RATE_56, 3'h2}, 14'h0540,
              {9'h003, 9'h017, 9'h00a, 9'h006},
              {5'h0d, 5'h08, 5'h0d, 5'h17},
              4'h8);
    bad_cfg(frame_cfg_t'{1'b0, `PS_RATE_80, 3'h1});
    bad_cfg(frame_cfg_t'{1'b0, `PS_RATE_56, 3'h1});
    bad_cfg(frame_cfg_t'{1'b0, `PS_RATE_32, 3'h0});
    bad_cfg(frame_cfg_t'{1'b0, `PS_RATE_48, 3'h6});
    bad_cfg(frame_cfg_t'{1'b0, `PS_RATE_64, 3'h7});
    test_done();
  end
endmodule
`default_nettype wire

// file: common/puncture_params.svh
// constants of the puncturing sequencer: counts, rate codes, tail vector
// assumes inclusion by bare name from the package and the design module
`ifndef PUNCTURE_PARAMS_SVH
`define PUNCTURE_PARAMS_SVH

`define PS_BLOCK_BITS      128
`define PS_SUB_BLOCK_BITS  32
`define PS_SUBS_PER_BLOCK  4
`define PS_LAST_SUB        2'h3
`define PS_SEGMENTS        4
`define PS_TAIL_BITS       24
`define PS_TAIL_KEPT       12
`define PS_TAIL_VECTOR     24'hcccccc
`define PS_PAD_ALIGN       64
`define PS_LEVEL_MIN       3'h1
`define PS_LEVEL_MAX       3'h5
// fast info channel profile
`define PS_FAST_FRAME_BITS  14'h0300
`define PS_FAST_SEG1_BLOCKS 21
`define PS_FAST_SEG2_BLOCKS 3
`define PS_FAST_SEG1_INDEX  16
`define PS_FAST_SEG2_INDEX  15
// sub-channel bit rate select codes
`define PS_RATE_32   4'h0
`define PS_RATE_48   4'h1
`define PS_RATE_56   4'h2
`define PS_RATE_64   4'h3
`define PS_RATE_80   4'h4
`define PS_RATE_96   4'h5
`define PS_RATE_112  4'h6
`define PS_RATE_128  4'h7
`define PS_RATE_160  4'h8
`define PS_RATE_192  4'h9
`define PS_RATE_224  4'ha
`define PS_RATE_256  4'hb
`define PS_RATE_320  4'hc
`define PS_RATE_384  4'hd

`endif

// file: common/puncture_pkg.sv
// types shared by the puncturing sequencer and its bench
// assumes the params header sits beside it on the include path
`default_nettype none
`include "puncture_params.svh"

package puncture_pkg;

  typedef enum logic [1:0] {
    BEAT_BLOCK,
    BEAT_TAIL,
    BEAT_PAD
  } beat_kind_t;

  // one output beat: a sub-block, the tail, or the padding
  typedef struct packed {
    beat_kind_t  kind;
    logic [8:0]  block_num;
    logic [1:0]  sub_block;
    logic [4:0]  puncture_index;
    logic [23:0] tail_vector;
    logic [3:0]  pad_bits;
    logic        last;
  } beat_t;

  // frame configuration sampled at start of frame
  typedef struct packed {
    logic       fast_info_channel;
    logic [3:0] rate_sel;
    logic [2:0] level;
  } frame_cfg_t;

  typedef struct packed {
    logic            ok;
    logic [3:0][7:0] seg_blocks;
    logic [3:0][4:0] seg_index;
    logic [3:0]      pad_bits;
  } profile_t;

endpackage

`default_nettype wire

// file: hw/puncture_sequencer.sv
// puncturing sequencer: per frame, one beat per 32-bit sub-block naming
// its puncture index, then one tail beat, then an optional padding beat.
// assumes the downstream puncturer holds the vector table and applies it.
`timescale 1ns/1ps
`default_nettype none
`include "puncture_params.svh"

// Function
// - Fast info channel mode treats each 768-bit scrambled vector as one frame.
// - Fast info channel mode splits the codeword body into 24 blocks of 128 bits.
// - Fast info channel blocks 0 to 20 use puncture index 16.
// - Fast info channel blocks 21 to 23 use puncture index 15.
// - Fast info channel frames end with the tail vector and carry no padding.
// - Unequal protection frame length and block count follow the bit rate.
// - Unequal protection blocks run through four segments, each its own index.
// - Unequal protection frames puncture the 24 tail bits after all blocks.
// - Five protection levels with the bit rate select the profile.
// - Unequal protection frames append the profile's zero padding bits last.
// - Profiles follow the tabulated rows, an empty segment being skipped.
// - Each block goes out as four sub-blocks sharing one puncture index.
// - The tail is punctured with repeating 1100, keeping 12 bits.
// - Sub-blocks and blocks keep their order, tail follows, padding last.
module puncture_sequencer
  import puncture_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  input  wire logic   start_frame,
  input  wire frame_cfg_t cfg,
  output var  logic   busy,
  output var  logic   cfg_error,
  output var  logic [13:0] frame_bits,
  output var  beat_t  beat,
  output var  logic   beat_valid,
  input  wire logic   beat_ready
);

  typedef enum {ST_IDLE, ST_BLOCKS, ST_TAIL, ST_PAD} state_t;

  function automatic profile_t mk(input int b1, input int b2, input int b3,
                                  input int b4, input int i1, input int i2,
                                  input int i3, input int i4, input int pad);
    // element 0 is the first segment, so it sits at the low end
    return '{ok:         1'b1,
             seg_blocks: {8'(b4), 8'(b3), 8'(b2), 8'(b1)},
             seg_index:  {5'(i4), 5'(i3), 5'(i2), 5'(i1)},
             pad_bits:   4'(pad)};
  endfunction

  // profile table; rows missing from it answer ok = 0
  function automatic profile_t lookup(input frame_cfg_t c);
    profile_t p;
    p = '0;
    if (c.fast_info_channel) begin
      p = mk(`PS_FAST_SEG1_BLOCKS, `PS_FAST_SEG2_BLOCKS, 0, 0,
             `PS_FAST_SEG1_INDEX, `PS_FAST_SEG2_INDEX, 0, 0, 0);
    end else begin
      unique case ({c.rate_sel, c.level})
        {`PS_RATE_32, 3'h5}: p = mk(3, 4, 17, 0, 5, 3, 2, 0, 0);
        {`PS_RATE_32, 3'h4}: p = mk(3, 3, 18, 0, 11, 6, 5, 0, 0);
        {`PS_RATE_32, 3'h3}: p = mk(3, 4, 14, 3, 15, 9, 6, 8, 0);
        {`PS_RATE_32, 3'h2}: p = mk(3, 4, 14, 3, 22, 13, 8, 13, 0);
        {`PS_RATE_32, 3'h1}: p = mk(3, 5, 13, 3, 24, 17, 12, 17, 4);
        {`PS_RATE_48, 3'h5}: p = mk(4, 3, 26, 3, 5, 4, 2, 3, 0);
        {`PS_RATE_48, 3'h4}: p = mk(3, 4, 26, 3, 9, 6, 4, 6, 0);
        {`PS_RATE_48, 3'h3}: p = mk(3, 4, 26, 3, 15, 10, 6, 9, 4);
        {`PS_RATE_48, 3'h2}: p = mk(3, 4, 26, 3, 24, 14, 8, 15, 0);
        {`PS_RATE_48, 3'h1}: p = mk(3, 5, 25, 3, 24, 18, 13, 18, 0);
        {`PS_RATE_56, 3'h5}: p = mk(6, 10, 23, 3, 5, 4, 2, 3, 0);
        {`PS_RATE_56, 3'h4}: p = mk(6, 10, 23, 3, 9, 6, 4, 5, 0);
        {`PS_RATE_56, 3'h3}: p = mk(6, 12, 21, 3, 16, 7, 6, 9, 0);
        {`PS_RATE_56, 3'h2}: p = mk(6, 10, 23, 3, 23, 13, 8, 13, 8);
        {`PS_RATE_64, 3'h5}: p = mk(6, 9, 31, 2, 5, 3, 2, 3, 0);
        {`PS_RATE_64, 3'h4}: p = mk(6, 9, 33, 0, 11, 6, 5, 0, 0);
        {`PS_RATE_64, 3'h3}: p = mk(6, 12, 27, 3, 16, 8, 6, 9, 0);
        {`PS_RATE_64, 3'h2}: p = mk(6, 10, 29, 3, 23, 13, 8, 13, 8);
        {`PS_RATE_64, 3'h1}: p = mk(6, 11, 28, 3, 24, 18, 12, 18, 4);
        default:             p = '0;
      endcase
    end
    return p;
  endfunction

  // body length in bits per rate: 32 bits of input per block
  function automatic logic [13:0] rate_bits(input logic [3:0] r);
    logic [13:0] b;
    unique case (r)
      `PS_RATE_32:  b = 14'h0300;
      `PS_RATE_48:  b = 14'h0480;
      `PS_RATE_56:  b = 14'h0540;
      `PS_RATE_64:  b = 14'h0600;
      `PS_RATE_80:  b = 14'h0780;
      `PS_RATE_96:  b = 14'h0900;
      `PS_RATE_112: b = 14'h0a80;
      `PS_RATE_128: b = 14'h0c00;
      `PS_RATE_160: b = 14'h0f00;
      `PS_RATE_192: b = 14'h1200;
      `PS_RATE_224: b = 14'h1500;
      `PS_RATE_256: b = 14'h1800;
      `PS_RATE_320: b = 14'h1e00;
      `PS_RATE_384: b = 14'h2400;
      default:      b = 14'h0000;
    endcase
    return b;
  endfunction

  state_t      state_reg, state_next;
  profile_t    profile_reg;
  logic [1:0]  seg_reg;
  logic [7:0]  left_reg;
  logic [1:0]  sub_reg;
  logic [8:0]  blk_reg;
  logic        valid_reg;
  beat_t       beat_reg;
  logic        err_reg;
  logic [13:0] bits_reg;

  // start_prof, level_ok and start_ok decoded live from cfg; profile_reg keeps the copy taken at frame start so mid-frame changes cannot tear it
  profile_t    start_prof;
  logic        level_ok;
  logic        start_ok;
  logic        advance;
  logic        last_sub;
  logic        seg_done;
  logic [1:0]  next_seg;
  logic        more_segs;

  assign level_ok   = cfg.fast_info_channel ||
                      (cfg.level >= `PS_LEVEL_MIN &&
                       cfg.level <= `PS_LEVEL_MAX);
  assign start_prof = lookup(cfg);
  assign start_ok   = start_prof.ok && level_ok;
  // output slot free when empty or being taken this cycle
  assign advance    = !valid_reg || beat_ready;
  assign last_sub   = sub_reg == `PS_LAST_SUB;
  assign seg_done   = last_sub && left_reg == 8'h01;

  // first later segment with blocks; empty ones are skipped
  always_comb begin
    next_seg  = seg_reg;
    more_segs = 1'b0;
    for (int k = `PS_SEGMENTS - 1; k > 0; k--) begin
      if (k > seg_reg && profile_reg.seg_blocks[k] != 8'h00) begin
        next_seg  = 2'(k);
        more_segs = 1'b1;
      end
    end
  end

  // frame sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:   if (start_frame && start_ok) state_next = ST_BLOCKS;
      ST_BLOCKS: if (advance && seg_done && !more_segs)
                   state_next = ST_TAIL;
      ST_TAIL:   if (advance)
                   state_next = (profile_reg.pad_bits != 4'h0) ? ST_PAD
                                                               : ST_IDLE;
      ST_PAD:    if (advance) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // configuration latch and error flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      profile_reg <= '0;
      bits_reg    <= 14'h0000;
      err_reg     <= 1'b0;
    end else begin
      err_reg <= state_reg == ST_IDLE && start_frame && !start_ok;
      if (state_reg == ST_IDLE && start_frame && start_ok) begin
        profile_reg <= start_prof;
        bits_reg    <= cfg.fast_info_channel ? `PS_FAST_FRAME_BITS
                                             : rate_bits(cfg.rate_sel);
      end
    end
  end

  // block, sub-block and segment counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seg_reg  <= 2'h0;
      left_reg <= 8'h00;
      sub_reg  <= 2'h0;
      blk_reg  <= 9'h000;
    end else if (state_reg == ST_IDLE) begin
      seg_reg  <= 2'h0;
      left_reg <= start_prof.seg_blocks[0];
      sub_reg  <= 2'h0;
      blk_reg  <= 9'h000;
    end else if (state_reg == ST_BLOCKS && advance) begin
      sub_reg <= sub_reg + 2'h1;
      if (last_sub) begin
        blk_reg <= blk_reg + 9'h001;
        if (seg_done) begin
          seg_reg  <= next_seg;
          left_reg <= profile_reg.seg_blocks[next_seg];
        end else begin
          left_reg <= left_reg - 8'h01;
        end
      end
    end
  end

  // output beat register, refilled whenever the slot is free
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
      beat_reg  <= '0;
    end else if (advance) begin
      valid_reg <= state_reg != ST_IDLE;
      beat_reg  <= '0;
      unique case (state_reg)
        ST_BLOCKS: begin
          beat_reg.kind           <= BEAT_BLOCK;
          beat_reg.block_num      <= blk_reg;
          beat_reg.sub_block      <= sub_reg;
          beat_reg.puncture_index <= profile_reg.seg_index[seg_reg];
        end
        ST_TAIL: begin
          beat_reg.kind        <= BEAT_TAIL;
          beat_reg.tail_vector <= `PS_TAIL_VECTOR;
          beat_reg.last        <= profile_reg.pad_bits == 4'h0;
        end
        ST_PAD: begin
          beat_reg.kind     <= BEAT_PAD;
          beat_reg.pad_bits <= profile_reg.pad_bits;
          beat_reg.last     <= 1'b1;
        end
        ST_IDLE: beat_reg <= '0;
      endcase
    end
  end

  assign busy       = state_reg != ST_IDLE;
  assign cfg_error  = err_reg;
  assign frame_bits = bits_reg;
  assign beat       = beat_reg;
  assign beat_valid = valid_reg;

  property p_fast_high;
    @(posedge mclk) disable iff (!rst_n)
    beat_valid && beat.kind == BEAT_BLOCK && frame_bits ==
      `PS_FAST_FRAME_BITS && profile_reg.seg_index[0] == 5'h10 &&
      beat.block_num < 9'h015 |-> beat.puncture_index == 5'h10;
  endproperty
  a_fast_high: assert property (p_fast_high)
    else $error("early fast info block has wrong index");
  property p_fast_low;
    @(posedge mclk) disable iff (!rst_n)
    beat_valid && beat.kind == BEAT_BLOCK && profile_reg.seg_index[0] ==
      5'h10 && profile_reg.seg_blocks[0] == 8'h15 &&
      beat.block_num >= 9'h015 |-> beat.puncture_index == 5'h0f;
  endproperty
  a_fast_low: assert property (p_fast_low)
    else $error("late fast info block has wrong index");

  property p_sub_order;
    @(posedge mclk) disable iff (!rst_n)
    beat_valid && beat_ready && beat.kind == BEAT_BLOCK &&
      beat.sub_block != 2'h3 ##1 beat_valid |->
      beat.kind == BEAT_BLOCK &&
      beat.sub_block == $past(beat.sub_block) + 2'h1 &&
      beat.puncture_index == $past(beat.puncture_index);
  endproperty
  a_sub_order: assert property (p_sub_order)
    else $error("sub-blocks out of order or index changed");

  property p_tail_vec;
    @(posedge mclk) disable iff (!rst_n)
    beat_valid && beat.kind == BEAT_TAIL |->
      beat.tail_vector == 24'hcccccc;
  endproperty
  a_tail_vec: assert property (p_tail_vec)
    else $error("tail vector wrong");

  property p_tail_after;
    @(posedge mclk) disable iff (!rst_n)
    beat_valid && beat_ready && beat.kind == BEAT_TAIL && !beat.last
      |-> ##[1:2] beat_valid && beat.kind == BEAT_PAD;
  endproperty
  a_tail_after: assert property (p_tail_after)
    else $error("padding beat missing after tail");

  property p_err_quiet;
    @(posedge mclk) disable iff (!rst_n)
    cfg_error |-> !busy ##1 !busy;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("frame started despite config error");

  property p_latch;
    @(posedge mclk) disable iff (!rst_n)
    busy && $past(busy) |-> $stable(profile_reg) && $stable(frame_bits);
  endproperty
  a_latch: assert property (p_latch)
    else $error("configuration changed mid frame");

  property p_blocks_end;
    @(posedge mclk) disable iff (!rst_n)
    state_reg == ST_BLOCKS ##1 state_reg == ST_TAIL |->
      blk_reg == 9'(profile_reg.seg_blocks[0] + profile_reg.seg_blocks[1]
                    + profile_reg.seg_blocks[2] + profile_reg.seg_blocks[3]);
  endproperty
  a_blocks_end: assert property (p_blocks_end)
    else $error("block count differs from profile total");

endmodule

`default_nettype wire
